// ### hdl/rwcm_cfg.svh
// Purpose: Constants for the reset, watchdog and clock monitor block
// Assumes: One clock, clk_sys, which is the E clock (one bus cycle per rising edge)
// Notes:   Offsets are register addresses on the plain 8-bit register port
`ifndef RWCM_CFG_SVH
`define RWCM_CFG_SVH

// ==========================================================
// Register addresses
`define RWCM_ADDR_STATUS 8'h30
`define RWCM_ADDR_OPTION 8'h39
`define RWCM_ADDR_SERVICE 8'h3a
`define RWCM_ADDR_TEST 8'h3e
`define RWCM_ADDR_CONFIG 8'h3f

// ==========================================================
// Field positions
`define RWCM_OPT_ADPU 7
`define RWCM_OPT_CSEL 6
`define RWCM_OPT_IRQ_EDGE 5
`define RWCM_OPT_DLY 4
`define RWCM_OPT_CLKMON_EN 3
`define RWCM_OPT_RATE_HI 1
`define RWCM_OPT_RATE_LO 0
`define RWCM_CFG_WDOG_OFF 2
`define RWCM_TEST_RST_INHIBIT 2

// ==========================================================
// Reset values and write masks
`define RWCM_OPTION_RST 8'h10
`define RWCM_OPTION_IMPL 8'hfb
`define RWCM_OPTION_PROT 8'h33
`define RWCM_CONFIG_RST 8'h00
`define RWCM_SVC_ARM 8'h55
`define RWCM_SVC_CLEAR 8'haa

// ==========================================================
// Timing (the time unit is one E-clock cycle)
`define RWCM_POR_DELAY_TCYC 4064
`define RWCM_POR_DELAY_CYC (`RWCM_POR_DELAY_TCYC)
`define RWCM_PIN_DRIVE_TCYC 4
`define RWCM_PIN_DRIVE_CYC (`RWCM_PIN_DRIVE_TCYC)
`define RWCM_PIN_SAMPLE_TCYC 2
`define RWCM_PIN_SAMPLE_CYC (`RWCM_PIN_SAMPLE_TCYC)
`define RWCM_OPT_WINDOW_CYC 64
`define RWCM_WDOG_PRESCALE 32768

// ==========================================================
// Reset vectors
`define RWCM_VEC_NORMAL_HI 8'hff
`define RWCM_VEC_SPECIAL_HI 8'hbf
`define RWCM_VEC_PIN_LO 8'hfe
`define RWCM_VEC_CM_LO 8'hfc
`define RWCM_VEC_WD_LO 8'hfa

`endif

// ### hdl/rwcm_pkg.sv
// Purpose: Types shared by the reset, watchdog and clock monitor block
// Assumes: Constants come from rwcm_cfg.svh
// Notes:   States are binary coded
package rwcm_pkg;

  // ==========================================================
  // Reset sequencer states
  typedef enum logic [2:0] {
    RST_POR = 3'b000, // Power-up stabilisation wait
    RST_DRIVE = 3'b001, // Pulling the reset pin low
    RST_SETTLE = 3'b010, // Pin released, waiting to sample
    RST_HOLD = 3'b011, // External party still holds pin low
    RST_RUN = 3'b100 // Out of reset
  } rwcm_rst_state_type;

  // Cause of the most recent reset
  typedef enum logic [1:0] {
    CAUSE_POR = 2'b00,
    CAUSE_PIN = 2'b01,
    CAUSE_CLKMON = 2'b10,
    CAUSE_WDOG = 2'b11
  } rwcm_cause_type;

  // Watchdog rate code
  typedef logic [1:0] rwcm_rate_type;

  // Watchdog counter state
  typedef struct packed {
    logic [15:0] pre; // E/2^15 prescaler
    logic [5:0] div; // Rate divider
    logic timeout; // One-cycle timeout pulse
  } rwcm_wdog_state_type;

endpackage

// ### hdl/rwcm_wdog_if.sv
// Purpose: Control and status between the sequencer and the watchdog counter
// Assumes: Both ends run on clk_sys
// Notes:   Plain signals, no clocking block
`timescale 1ns/1ps
interface rwcm_wdog_if;
  logic restart; // Hold counter at zero
  logic clear; // One-cycle valid service pulse
  logic enable; // Timeout may request reset
  rwcm_pkg::rwcm_rate_type rate; // Rate code
  logic timeout; // One-cycle timeout pulse

  modport ctrl (output restart, output clear, output enable, output rate, input timeout);
  modport cnt (input restart, input clear, input enable, input rate, output timeout);
endinterface

// ### hdl/rwcm_wdog.sv
// Purpose: Watchdog counter with E/2^15 prescaler and rate divider
// Assumes: Counts only on clk_sys edges
// Notes:   PRESCALE can be shortened in simulation
`timescale 1ns/1ps
`include "rwcm_cfg.svh"
module rwcm_wdog #(
  parameter int PRESCALE = `RWCM_WDOG_PRESCALE
) (
  input wire logic clk_sys,
  input wire logic rst,
  rwcm_wdog_if.cnt wd
);
  import rwcm_pkg::*;

  // Copy of state, next value
  rwcm_wdog_state_type wd_reg;
  rwcm_wdog_state_type wd_next;

  // Last divider count for a rate code: 1, 4, 16 or 64 prescaler periods
  function automatic logic [5:0] div_last(input rwcm_rate_type r);
    case (r)
      2'b00: div_last = 6'h00;
      2'b01: div_last = 6'h03;
      2'b10: div_last = 6'h0f;
      default: div_last = 6'h3f;
    endcase
  endfunction

  // ==========================================================
  // Counting
  // Nothing advances without a clock edge, so a stopped clock freezes us
  always_comb begin
    wd_next = wd_reg;
    wd_next.timeout = 1'b0;
    if (wd.restart || wd.clear) begin
      wd_next.pre = 16'h0000;
      wd_next.div = 6'h00;
    end else if (wd_reg.pre == 16'(PRESCALE - 1)) begin
      wd_next.pre = 16'h0000;
      if (wd_reg.div >= div_last(wd.rate)) begin
        // Timeout only counts when enabled; the counter wraps either way
        wd_next.div = 6'h00;
        wd_next.timeout = wd.enable;
      end else begin
        wd_next.div = wd_reg.div + 6'h01;
      end
    end else begin
      wd_next.pre = wd_reg.pre + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wd_reg <= '0;
    end else begin
      wd_reg <= wd_next;
    end
  end

  assign wd.timeout = wd_reg.timeout;

endmodule

// ### hdl/rwcm_top.sv
// Purpose: Reset sequencer, reset pin, watchdog control, clock monitor, option bits
// Assumes: clk_sys is the E clock; rst is the power-on reset
// Notes:   The RC clock monitor cell is analog and sits outside; we take its flag
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "rwcm_cfg.svh"
module rwcm_top #(
  parameter int WDOG_PRESCALE = `RWCM_WDOG_PRESCALE
) (
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  // Open-drain reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Mode and clock monitor inputs
  input wire logic special_mode,
  input wire logic rc_clock_missing,
  input wire logic stop_mode,
  // External interrupt pin
  input wire logic irq_pin_n,
  input wire logic irq_ack,
  output logic irq_request,
  // To the processor and peripherals
  output logic cpu_reset,
  output logic [15:0] reset_vector,
  output rwcm_pkg::rwcm_cause_type reset_cause,
  output logic adc_power_up,
  output logic adc_clock_select,
  output logic osc_delay_enable
);
  import rwcm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    rwcm_rst_state_type st; // Sequencer state
    logic [11:0] cnt; // Delay counter for the sequencer
    rwcm_cause_type cause; // Cause of current or last reset
    logic cpu_reset; // Processor held in reset
    logic pin_oe; // Driving the reset pin
    logic pin_out; // Level driven onto the pin (always low)
    logic [15:0] vector; // Selected reset vector
    logic [7:0] option; // System options
    logic opt_written; // Protected option bits used their one write
    logic [6:0] bus_cyc; // Cycles since leaving reset, saturating
    logic [7:0] config_nv; // Nonvolatile setup cell
    logic wdog_off_act; // Watchdog disable in effect since last reset
    logic special; // Mode latched at reset exit
    logic rst_inhibit; // Disable-resets test bit
    logic armed; // Service sequence armed by 55
    logic svc_clear; // Valid service pulse to the counter
    logic wd_restart; // Hold the watchdog counter at zero
    logic irq_req; // Interrupt request
    logic irq_prev_n; // Previous interrupt pin level
    logic [7:0] rd_data; // Read data
  } rwcm_main_state_type;

  rwcm_main_state_type s_reg;
  rwcm_main_state_type s_next;

  // Link to the watchdog counter
  rwcm_wdog_if wd_link ();

  // Clock failure as seen through the enable bit
  logic clkmon_fail;

  // ==========================================================
  // Helper functions
  // Vector for a cause and mode; power-up and pin share one
  function automatic logic [15:0] pick_vector(input rwcm_cause_type c, input logic spec);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = spec ? `RWCM_VEC_SPECIAL_HI : `RWCM_VEC_NORMAL_HI;
    case (c)
      CAUSE_CLKMON: lo = `RWCM_VEC_CM_LO;
      CAUSE_WDOG: lo = `RWCM_VEC_WD_LO;
      default: lo = `RWCM_VEC_PIN_LO;
    endcase
    pick_vector = {hi, lo};
  endfunction

  // Protected option bits may be written now
  // The window is counted in bus cycles from the end of reset, so a long
  // external reset does not eat into the time software has to set the rate
  function automatic logic prot_open(input rwcm_main_state_type s);
    prot_open = s.special || (!s.opt_written && (s.bus_cyc < 7'(`RWCM_OPT_WINDOW_CYC)));
  endfunction

  // ==========================================================
  // Clock monitor
  // The RC cell flags a slow or stopped clock by itself; stop mode halts
  // the clock, so it trips the monitor just the same when enabled.
  // The 10 kHz / 200 kHz thresholds belong to the RC cell.
  // Limitation: the flag is only acted on at a clock edge here; a fully
  // stopped clock must reset the core through the cell's own reset path.
  // Stop mode is folded in so software can use it as a deliberate reset.
  assign clkmon_fail = s_reg.option[`RWCM_OPT_CLKMON_EN] && (rc_clock_missing || stop_mode);

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.svc_clear = 1'b0;
    s_next.pin_out = 1'b0;
    s_next.rd_data = 8'h00;

    // ----------------------------------------------------------
    // Reset sequencer
    case (s_reg.st)
      // Power-up: wait for the clock generator to settle
      RST_POR: begin
        if (s_reg.cnt == 12'(`RWCM_POR_DELAY_CYC - 1)) begin
          s_next.st = RST_DRIVE;
          s_next.cnt = 12'h000;
          s_next.pin_oe = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 12'h001;
        end
      end
      // Pull the pin low so the whole system sees the reset
      RST_DRIVE: begin
        if (s_reg.cnt == 12'(`RWCM_PIN_DRIVE_CYC - 1)) begin
          s_next.st = RST_SETTLE;
          s_next.cnt = 12'h000;
          s_next.pin_oe = 1'b0;
        end else begin
          s_next.cnt = s_reg.cnt + 12'h001;
        end
      end
      // Pin released; a slow external RC here would be read as external
      RST_SETTLE: begin
        if (s_reg.cnt == 12'(`RWCM_PIN_SAMPLE_CYC - 1)) begin
          s_next.cnt = 12'h000;
          if (!reset_pin_in) begin
            // Still low: someone outside holds it
            if (s_reg.cause != CAUSE_POR) begin
              s_next.cause = CAUSE_PIN;
            end
            s_next.st = RST_HOLD;
          end else begin
            s_next.st = RST_RUN;
          end
        end else begin
          s_next.cnt = s_reg.cnt + 12'h001;
        end
      end
      // Wait for the external party to let go
      RST_HOLD: begin
        if (reset_pin_in) begin
          s_next.st = RST_RUN;
        end
      end
      // Running: watch for new reset causes, pin first, then clock, then watchdog
      // Any cause seen here restarts the full drive and sample sequence,
      // so the rest of the board always sees at least four low cycles
      RST_RUN: begin
        if (!reset_pin_in) begin
          s_next.cause = CAUSE_PIN;
          s_next.st = RST_DRIVE;
          s_next.pin_oe = 1'b1;
          s_next.cpu_reset = 1'b1;
        end else if (clkmon_fail) begin
          s_next.cause = CAUSE_CLKMON;
          s_next.st = RST_DRIVE;
          s_next.pin_oe = 1'b1;
          s_next.cpu_reset = 1'b1;
        end else if (wd_link.timeout) begin
          s_next.cause = CAUSE_WDOG;
          s_next.st = RST_DRIVE;
          s_next.pin_oe = 1'b1;
          s_next.cpu_reset = 1'b1;
        end
        s_next.cnt = 12'h000;
      end
      default: begin
        s_next.st = RST_POR;
        s_next.cnt = 12'h000;
      end
    endcase

    // ----------------------------------------------------------
    // Leaving reset: latch mode, watchdog enable and vector
    if (s_reg.st != RST_RUN && s_next.st == RST_RUN) begin
      s_next.cpu_reset = 1'b0;
      s_next.special = special_mode;
      s_next.vector = pick_vector(s_next.cause, special_mode);
      // Setup bit is only looked at here, so a runaway program cannot
      // switch the watchdog off without also passing through a reset
      s_next.wdog_off_act = s_reg.config_nv[`RWCM_CFG_WDOG_OFF];
      s_next.rst_inhibit = special_mode;
    end

    // ----------------------------------------------------------
    // Control bits forced to their initial state during reset
    if (s_reg.cpu_reset) begin
      s_next.option = `RWCM_OPTION_RST;
      s_next.opt_written = 1'b0;
      s_next.bus_cyc = 7'h00;
      s_next.armed = 1'b0;
      s_next.wd_restart = 1'b1;
      s_next.irq_req = 1'b0;
    end else begin
      s_next.wd_restart = 1'b0;
      // Count bus cycles up to the end of the early-write window
      if (s_reg.bus_cyc < 7'(`RWCM_OPT_WINDOW_CYC)) begin
        s_next.bus_cyc = s_reg.bus_cyc + 7'h01;
      end

      // --------------------------------------------------------
      // Register writes (ignored while the processor is in reset)
      if (reg_wr) begin
        case (reg_addr)
          `RWCM_ADDR_OPTION: begin
            // Monitor enable and converter bits can change at any time
            s_next.option = (s_reg.option & `RWCM_OPTION_PROT) |
                            (reg_wr_data & `RWCM_OPTION_IMPL & ~`RWCM_OPTION_PROT);
            if (prot_open(s_reg)) begin
              s_next.option = s_next.option & ~`RWCM_OPTION_PROT |
                              (reg_wr_data & `RWCM_OPTION_PROT);
              s_next.opt_written = 1'b1;
            end
          end
          `RWCM_ADDR_SERVICE: begin
            // Other accesses may fall between the two writes
            if (reg_wr_data == `RWCM_SVC_ARM) begin
              s_next.armed = 1'b1;
            end else if (reg_wr_data == `RWCM_SVC_CLEAR && s_reg.armed) begin
              s_next.armed = 1'b0;
              s_next.svc_clear = 1'b1;
            end
            // A clear without arming does nothing at all
            // Other values leave the arm flag as it was
          end
          `RWCM_ADDR_CONFIG: begin
            // Stored only; takes effect at the next reset
            s_next.config_nv = reg_wr_data;
          end
          `RWCM_ADDR_TEST: begin
            // Normal mode never lets software inhibit watchdog resets
            if (s_reg.special) begin
              s_next.rst_inhibit = reg_wr_data[`RWCM_TEST_RST_INHIBIT];
            end
          end
          default: begin
            // Unmapped address: write ignored
          end
        endcase
      end

      // --------------------------------------------------------
      // External interrupt pin
      if (s_reg.option[`RWCM_OPT_IRQ_EDGE]) begin
        // Edge mode: a falling edge sets, acknowledge clears, set wins
        if (s_reg.irq_prev_n && !irq_pin_n) begin
          s_next.irq_req = 1'b1;
        end else if (irq_ack) begin
          s_next.irq_req = 1'b0;
        end
      end else begin
        // Level mode suits wired-OR sources: follows the pin
        s_next.irq_req = !irq_pin_n;
      end
    end
    s_next.irq_prev_n = irq_pin_n;

    // ----------------------------------------------------------
    // Register reads, answered in the next cycle
    if (reg_rd) begin
      case (reg_addr)
        `RWCM_ADDR_OPTION: s_next.rd_data = s_reg.option & `RWCM_OPTION_IMPL;
        `RWCM_ADDR_CONFIG: s_next.rd_data = s_reg.config_nv;
        `RWCM_ADDR_TEST: s_next.rd_data = {5'h00, s_reg.rst_inhibit, 2'b00};
        // Status lets boot code tell why it was restarted and in which mode
        // without a separate flag register per cause
        `RWCM_ADDR_STATUS: s_next.rd_data = {2'b00, s_reg.special, s_reg.armed,
                                             s_reg.wdog_off_act, s_reg.opt_written, s_reg.cause};
        default: s_next.rd_data = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // State register
  // POR starts with reset asserted and the power-up delay running
  // Only the power-on input clears everything; internal causes go through
  // the sequencer so the setup cell survives them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= RST_POR;
      s_reg.cause <= CAUSE_POR;
      s_reg.cpu_reset <= 1'b1;
      s_reg.vector <= {`RWCM_VEC_NORMAL_HI, `RWCM_VEC_PIN_LO};
      s_reg.option <= `RWCM_OPTION_RST;
      s_reg.config_nv <= `RWCM_CONFIG_RST;
      s_reg.wd_restart <= 1'b1;
      s_reg.irq_prev_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Watchdog counter
  // Disabled by the setup bit latched at reset or by the test bit
  assign wd_link.restart = s_reg.wd_restart;
  assign wd_link.clear = s_reg.svc_clear;
  // The counter keeps running while disabled; only its timeout is masked,
  // so enabling it later never waits for a stale count to be reloaded
  assign wd_link.enable = !s_reg.wdog_off_act && !s_reg.rst_inhibit;
  // A rate change takes effect at the next prescaler wrap, not at the next divider wrap
  assign wd_link.rate = s_reg.option[`RWCM_OPT_RATE_HI:`RWCM_OPT_RATE_LO];

  rwcm_wdog #(
    .PRESCALE(WDOG_PRESCALE)
  ) u_wdog (
    .clk_sys(clk_sys),
    .rst(rst),
    .wd(wd_link)
  );

  // ==========================================================
  // Outputs, all straight from the state register
  // Nothing here is combinational, so outputs cannot glitch while the
  // sequencer moves between states
  assign reg_rd_data = s_reg.rd_data;
  assign reset_pin_out = s_reg.pin_out;
  assign reset_pin_oe = s_reg.pin_oe;
  assign irq_request = s_reg.irq_req;
  assign cpu_reset = s_reg.cpu_reset;
  assign reset_vector = s_reg.vector;
  assign reset_cause = s_reg.cause;
  assign adc_power_up = s_reg.option[`RWCM_OPT_ADPU];
  assign adc_clock_select = s_reg.option[`RWCM_OPT_CSEL];
  assign osc_delay_enable = s_reg.option[`RWCM_OPT_DLY];

endmodule

// ### dv/rwcm_top_sva.sv
// Purpose: Port-level timing checks for the reset, watchdog and clock monitor block
// Assumes: One clock domain, rst is asynchronous and active high
// Notes:   Bound to rwcm_top from tb_top; watches the reset pin input and what the block drives
`timescale 1ns/1ps
module rwcm_top_sva
  import rwcm_pkg::*;
#(
  parameter int WDOG_PRESCALE = 32768
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic cpu_reset,
  input wire logic [15:0] reset_vector,
  input wire rwcm_pkg::rwcm_cause_type reset_cause
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================
  // Helper: cycles from power-up release to the first pin drive
  logic [12:0] por_cnt_reg; // Edges counted since rst fell
  logic por_seen_reg; // First pin drive already seen

  // Counter freezes once the pin is first driven
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_cnt_reg <= 13'h0000;
      por_seen_reg <= 1'b0;
    end else begin
      if (!por_seen_reg) begin
        por_cnt_reg <= por_cnt_reg + 13'h0001;
      end
      if (reset_pin_oe) begin
        por_seen_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Assertions
  a_por_delay_len: assert property ($rose(reset_pin_oe) && !por_seen_reg |->
    por_cnt_reg >= 13'h0fe0 && por_cnt_reg <= 13'h0fe4) else $error("pin driven before stabilisation delay");
  a_pin_four_cycles: assert property ($rose(reset_pin_oe) |->
    reset_pin_oe [*4] ##1 !reset_pin_oe) else $error("pin drive not four cycles");
  a_pin_drive_low: assert property (reset_pin_oe |-> !reset_pin_out) else $error("pin driven high");
  a_oe_in_reset: assert property (reset_pin_oe |-> cpu_reset) else $error("pin driven outside reset");
  a_settle_hold: assert property ($fell(reset_pin_oe) |-> cpu_reset [*2]) else $error("left reset before sampling");
  a_exit_pin_high: assert property ($fell(cpu_reset) |-> $past(reset_pin_in)) else $error("left reset, pin low");
  a_pin_entry: assert property (!cpu_reset && !reset_pin_in |=>
    cpu_reset && reset_pin_oe) else $error("pin low ignored");
  a_vector_cause: assert property (!cpu_reset |->
    reset_vector[7:0] == (reset_cause == CAUSE_WDOG ? 8'hfa : reset_cause == CAUSE_CLKMON ? 8'hfc : 8'hfe)
    && (reset_vector[15:8] == 8'hff || reset_vector[15:8] == 8'hbf)) else $error("vector does not fit cause");
endmodule

// ### dv/rwcm_ext_rst.sv
// Purpose: External reset circuit on the open-drain reset line
// Assumes: The line has a pull-up, so a released line reads high
// Notes:   hold_low stands for a supervisor pulling the line down
`timescale 1ns/1ps
module rwcm_ext_rst (
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic hold_low,
  output logic reset_pin_in
);
  // ==========================================================
  // Wired level: low if either party pulls, else the pull-up wins
  assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || hold_low);
endmodule

// ### dv/tb_top.sv
// Purpose: Self-checking bench for the reset, watchdog and clock monitor block
// Assumes: Watchdog prescaler shortened to 32 so timeouts stay short
// Notes:   Random option values from a fixed seed
`timescale 1ns/1ps
`include "rwcm_cfg.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
  import rwcm_pkg::*;
  localparam int PRE = 32; // Short prescaler keeps the run brief
  logic clk_sys, rst, reg_wr, reg_rd, special_mode, rc_clock_missing, stop_mode, irq_pin_n, irq_ack, hold_low;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, v, w;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, irq_request, cpu_reset;
  logic adc_power_up, adc_clock_select, osc_delay_enable;
  logic [15:0] reset_vector;
  rwcm_cause_type reset_cause;
  int mismatches = 0;
  int check_count = 0;
  int seed = 15;
  int t, n;

  rwcm_top #(.WDOG_PRESCALE(PRE)) u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .special_mode(special_mode), .rc_clock_missing(rc_clock_missing), .stop_mode(stop_mode),
    .irq_pin_n(irq_pin_n), .irq_ack(irq_ack), .irq_request(irq_request), .cpu_reset(cpu_reset),
    .reset_vector(reset_vector), .reset_cause(reset_cause), .adc_power_up(adc_power_up),
    .adc_clock_select(adc_clock_select), .osc_delay_enable(osc_delay_enable));
  rwcm_ext_rst u_ext (.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .hold_low(hold_low),
    .reset_pin_in(reset_pin_in));

  // ==========================================================
  // 10 MHz clock, well above the monitor's safe limit
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Watchdog timeout in cycles for a rate code
  function automatic int wd_cycles(input logic [1:0] c);
    return PRE << (2 * c);
  endfunction

  // One-cycle write, then an idle cycle so strobes never double up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rd_data, e)
    @(posedge clk_sys);
  endtask

  // Bounded wait for cpu_reset to reach a level, sampled off the edge
  task automatic wait_lvl(input logic lvl, input int lim);
    int i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (cpu_reset !== lvl && i < lim);
    `CHK(cpu_reset, lvl)
    @(posedge clk_sys);
  endtask

  task automatic conclude();
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Hang guard, about two and a half times the expected run
  initial begin
    #2500000;
    mismatches++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, special_mode, rc_clock_missing, stop_mode, irq_ack, hold_low} = 7'h00;
    irq_pin_n = 1'b1;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    wait_lvl(1'b0, 5000);
    `CHK(reset_cause, CAUSE_POR)
    `CHK(reset_vector, 16'hfffe)
    // Every rate code: one early write, a second one that only the unprotected bits take, service, then starve
    for (int c = 0; c < 4; c++) begin
      rd(`RWCM_ADDR_OPTION, `RWCM_OPTION_RST);
      v = (8'($random(seed)) & 8'hd0) | 8'(c);
      wr(`RWCM_ADDR_OPTION, v | 8'h04);
      rd(`RWCM_ADDR_OPTION, v);
      w = v ^ 8'hc3;
      wr(`RWCM_ADDR_OPTION, w);
      rd(`RWCM_ADDR_OPTION, (v & 8'h33) | (w & 8'hc8));
      `CHK({adc_power_up, adc_clock_select, osc_delay_enable}, {w[7], w[6], v[4]})
      t = wd_cycles(2'(c));
      if (c == 3) begin
        irq_pin_n <= 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK(irq_request, 1'b1)
        @(posedge clk_sys);
        irq_pin_n <= 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(irq_request, 1'b0)
        @(posedge clk_sys);
        wr(`RWCM_ADDR_CONFIG, 8'h04);
      end
      repeat (3) begin
        wr(`RWCM_ADDR_SERVICE, `RWCM_SVC_ARM);
        rd(8'h40 | (8'($random(seed)) & 8'h3f), 8'h00);
        repeat (t / 4) @(posedge clk_sys);
        wr(`RWCM_ADDR_SERVICE, `RWCM_SVC_CLEAR);
      end
      `CHK(cpu_reset, 1'b0)
      repeat (4) @(posedge clk_sys);
      wr(`RWCM_ADDR_SERVICE, `RWCM_SVC_CLEAR);
      n = 7;
      while (cpu_reset !== 1'b1 && n < t + 40) begin
        @(negedge clk_sys);
        n++;
      end
      `CHK(n >= t + 1 && n <= t + 6, 1'b1)
      wait_lvl(1'b0, 100);
      `CHK(reset_cause, CAUSE_WDOG)
      `CHK(reset_vector, 16'hfffa)
    end
    // Edge mode: a short low pulse latches until acknowledged
    wr(`RWCM_ADDR_OPTION, 8'h20);
    rd(`RWCM_ADDR_OPTION, 8'h20);
    irq_pin_n <= 1'b0;
    @(posedge clk_sys);
    irq_pin_n <= 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK(irq_request, 1'b1)
    @(posedge clk_sys);
    irq_ack <= 1'b1;
    @(posedge clk_sys);
    irq_ack <= 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(irq_request, 1'b0)
    repeat (300) @(posedge clk_sys);
    `CHK(cpu_reset, 1'b0)
    // Clock monitor: missing clock, then stop mode
    for (int s = 0; s < 2; s++) begin
      wr(`RWCM_ADDR_OPTION, 8'h08);
      rd(`RWCM_ADDR_OPTION, s == 0 ? 8'h28 : 8'h08);
      if (s == 0) rc_clock_missing <= 1'b1;
      else stop_mode <= 1'b1;
      wait_lvl(1'b1, 5);
      {rc_clock_missing, stop_mode} <= 2'b00;
      wait_lvl(1'b0, 100);
      `CHK(reset_cause, CAUSE_CLKMON)
      `CHK(reset_vector, 16'hfffc)
      rd(`RWCM_ADDR_OPTION, `RWCM_OPTION_RST);
    end
    rc_clock_missing <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rc_clock_missing <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(cpu_reset, 1'b0)
    // External reset held long, special mode latched at exit
    wr(`RWCM_ADDR_CONFIG, 8'h00);
    special_mode <= 1'b1;
    hold_low <= 1'b1;
    wait_lvl(1'b1, 5);
    repeat (30) @(negedge clk_sys);
    `CHK(cpu_reset, 1'b1)
    @(posedge clk_sys);
    hold_low <= 1'b0;
    wait_lvl(1'b0, 50);
    `CHK(reset_cause, CAUSE_PIN)
    `CHK(reset_vector, 16'hbffe)
    rd(`RWCM_ADDR_STATUS, 8'h21);
    rd(`RWCM_ADDR_TEST, 8'h04);
    repeat (200) @(posedge clk_sys);
    `CHK(cpu_reset, 1'b0)
    wr(`RWCM_ADDR_TEST, 8'h00);
    wait_lvl(1'b1, 100);
    wait_lvl(1'b0, 50);
    `CHK(reset_cause, CAUSE_WDOG)
    `CHK(reset_vector, 16'hbffa)
    conclude();
  end
endmodule

bind rwcm_top rwcm_top_sva #(.WDOG_PRESCALE(WDOG_PRESCALE)) u_sva (.clk_sys(clk_sys), .rst(rst),
  .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
  .cpu_reset(cpu_reset), .reset_vector(reset_vector), .reset_cause(reset_cause));
